// ===== hw/sfr_status_regs.sv
// status flag register bank with its spi register slave
`timescale 1ns/10ps
`include "sfr_params.svh"

// Operation
// - idle register reads return all-zero data
// - idle register writes change nothing
// - status shows flags regardless of enable masks
// - event flags are active high
// - fast flag sets on fast mode entry
// - dc leadoff flag after condition exceeds 115ms
// - dc leadoff held until status read completes
// - leads-on flag reports detector leads-on condition
// - leads-on flag sets when select becomes 01/10
// - host status read clears flag, arms detection
// - leads-on flag held until status read completes
// - r event flag sets on new r wave
// - sample flag sets at chosen sample instants
// - pll flag only when powered and enabled
// - pll flag held until status read completes
// - four detail bits: ph, pl, nh, nl
// - detail bits set with dc leadoff flag
// - fast clear mode: level-held or read-cleared
// - r clear: status, rtor read, or self
// - sample clear: status read or quarter cycle
// - sample interval: every 1, 2, 4, 16
module sfr_status_regs #(
    parameter int LOFF_CYCLES = `SFR_LOFF_CYCLES   // lead-off qualify time in clocks
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        csb_n,
    input  wire logic        sclk,
    input  wire logic        sdi,
    output logic             sdo,
    input  wire logic        fast_mode_active,
    input  wire logic        dc_leadoff_cond,
    input  wire logic [3:0]  leadoff_detail,
    input  wire logic        leads_on_cond,
    input  wire logic        r_wave_pulse,
    input  wire logic        sample_instant,
    input  wire logic        pll_unlocked,
    input  wire logic        pll_powered,
    input  wire logic        channel_enable,
    input  wire logic [1:0]  lowpower_leadson_select,
    input  wire logic        fast_flag_clear_mode,
    input  wire logic [1:0]  r_event_clear_mode,
    input  wire logic        sample_sync_clear_mode,
    input  wire logic [1:0]  sample_sync_interval,
    output logic [23:0]      event_status
);
    import sfr_pkg::*;

    // ======================================================================
    // spi slave state
    sfr_spi_state_t state_reg,  state_next;   // frame position
    logic           sclk_reg;                 // last sclk level, for edges
    logic [4:0]     bit_reg,    bit_next;     // rising edges seen this frame
    logic [7:0]     cmd_reg,    cmd_next;     // {address, read}
    logic [23:0]    tx_reg,     tx_next;      // outgoing data shifter
    logic [23:0]    snap_reg,   snap_next;    // status as reported this frame
    logic           sdo_reg,    sdo_next;     // serial output bit
    logic           sclk_rise;                // sclk went high
    logic           sclk_fall;                // sclk went low
    logic           status_read;              // status frame finished
    logic           rtor_read;                // r-to-r interval frame finished
    logic [6:0]     rx_addr;                  // address of the running frame
    logic           rx_read;                  // frame is a read

    assign sclk_rise = sclk & ~sclk_reg;
    assign sclk_fall = ~sclk & sclk_reg;
    assign rx_addr   = cmd_reg[7:1];
    assign rx_read   = cmd_reg[0];
    assign sdo       = sdo_reg;

    // next values of the frame decoder
    always_comb begin
        state_next  = state_reg;
        bit_next    = bit_reg;
        cmd_next    = cmd_reg;
        tx_next     = tx_reg;
        snap_next   = snap_reg;
        sdo_next    = sdo_reg;
        status_read = 1'b0;
        rtor_read   = 1'b0;
        if (csb_n) begin
            // deselect aborts any frame; a cut frame never clears flags
            state_next = SFR_IDLE;
            bit_next   = 5'h00;
            sdo_next   = 1'b0;
        end else begin
            case (state_reg)
                SFR_IDLE: begin
                    state_next = SFR_CMD;
                    bit_next   = 5'h00;
                end
                SFR_CMD: begin
                    if (sclk_rise) begin
                        cmd_next = {cmd_reg[6:0], sdi};
                        bit_next = bit_reg + 5'h01;
                        if (bit_reg == `SFR_CMD_LAST_BIT) begin
                            state_next = SFR_DATA;
                            // only the status register yields data here;
                            // idle registers and all others shift out zero
                            if (sdi && cmd_reg[6:0] == `SFR_REG_STATUS) begin
                                tx_next   = event_status;
                                snap_next = event_status;
                            end else begin
                                tx_next   = `SFR_IDLE_READ;
                                snap_next = `SFR_FLAGS_RESET;
                            end
                        end
                    end
                end
                SFR_DATA: begin
                    // output changes on falling sclk, host samples on rising
                    if (sclk_fall) begin
                        sdo_next = tx_reg[23];
                        tx_next  = {tx_reg[22:0], 1'b0};
                    end
                    if (sclk_rise) begin
                        bit_next = bit_reg + 5'h01;
                        // write data is shifted past and dropped
                        if (bit_reg == `SFR_FRAME_LAST_BIT) begin
                            state_next  = SFR_DONE;
                            status_read = rx_read && (rx_addr == `SFR_REG_STATUS);
                            rtor_read   = rx_read && (rx_addr == `SFR_REG_RTOR);
                        end
                    end
                end
                SFR_DONE: begin
                    // wait for deselect; extra clocks are ignored
                    sdo_next = 1'b0;
                end
                default: begin
                    state_next = SFR_IDLE;
                end
            endcase
        end
    end

    // frame decoder registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= SFR_IDLE;
            sclk_reg  <= 1'b0;
            bit_reg   <= 5'h00;
            cmd_reg   <= 8'h00;
            tx_reg    <= 24'h000000;
            snap_reg  <= 24'h000000;
            sdo_reg   <= 1'b0;
        end else begin
            state_reg <= state_next;
            sclk_reg  <= sclk;
            bit_reg   <= bit_next;
            cmd_reg   <= cmd_next;
            tx_reg    <= tx_next;
            snap_reg  <= snap_next;
            sdo_reg   <= sdo_next;
        end
    end

    // ======================================================================
    // event flags
    logic        fast_reg,    fast_next;      // fast recovery flag
    logic        fast_prev_reg;               // fast mode seen last cycle
    logic        dcl_reg,     dcl_next;       // dc lead-off flag
    logic [3:0]  detail_reg,  detail_next;    // detailed lead-off bits
    logic [22:0] loff_cnt_reg, loff_cnt_next; // lead-off persistence timer
    logic        lon_reg,     lon_next;       // leads-on flag
    logic        lon_arm_reg, lon_arm_next;   // leads-on detection armed
    logic [1:0]  lon_sel_reg;                 // select seen last cycle
    logic        rev_reg,     rev_next;       // r event flag
    logic        sample_sync_flag_reg,    sample_sync_flag_next;      // sample sync flag
    logic [3:0]  sample_sync_flag_div_reg, sample_sync_flag_div_next; // sample instant divider
    logic [19:0] since_reg,   since_next;     // clocks since last instant
    logic [19:0] period_reg,  period_next;    // last sample period in clocks
    logic        pll_reg,     pll_next;       // pll unlock flag
    logic [23:0] clr;                         // bits reported by a finished read
    logic        loff_qual;                   // condition held beyond the limit
    logic        fast_enter;                  // fast mode just engaged
    logic        lon_sel_on;                  // select asks for leads-on mode
    logic        sample_sync_flag_issue;                  // this instant raises the flag
    logic [3:0]  sample_sync_flag_mask;                   // divider wrap mask

    // a status read clears only bits it actually shipped, so a set after the
    // snapshot survives to the next read
    assign clr        = snap_reg & {24{status_read}};
    assign loff_qual  = dc_leadoff_cond && (loff_cnt_reg > 23'(LOFF_CYCLES));
    assign fast_enter = fast_mode_active & ~fast_prev_reg;
    assign lon_sel_on = (lowpower_leadson_select == `SFR_LON_SEL_A) ||
                        (lowpower_leadson_select == `SFR_LON_SEL_B);

    // divider mask per interval code
    always_comb begin
        case (sample_sync_interval)
            2'h0:    sample_sync_flag_mask = 4'h0;
            2'h1:    sample_sync_flag_mask = 4'h1;
            2'h2:    sample_sync_flag_mask = 4'h3;
            default: sample_sync_flag_mask = 4'hf;
        endcase
    end
    assign sample_sync_flag_issue = sample_instant && ((sample_sync_flag_div_reg & sample_sync_flag_mask) == 4'h0);

    // next values of all flags; a set always wins over a same-cycle clear
    always_comb begin
        // fast recovery flag
        if (fast_flag_clear_mode) begin
            fast_next = fast_enter | (fast_reg & ~clr[`SFR_BIT_FAST]);
        end else begin
            fast_next = fast_mode_active | (fast_reg & ~clr[`SFR_BIT_FAST]);
        end

        // lead-off timer saturates just past the limit
        if (!dc_leadoff_cond) begin
            loff_cnt_next = 23'h000000;
        end else if (!loff_qual) begin
            loff_cnt_next = loff_cnt_reg + 23'h000001;
        end else begin
            loff_cnt_next = loff_cnt_reg;
        end
        dcl_next    = loff_qual | (dcl_reg & ~clr[`SFR_BIT_DCLOFF]);
        detail_next = ({4{loff_qual}} & leadoff_detail) |
                      (detail_reg & ~clr[`SFR_BIT_DETAIL_LO +: 4]);

        // leads-on: entering the mode flags it and disarms detection
        lon_arm_next = lon_arm_reg;
        lon_next     = lon_reg;
        if (!lon_sel_on) begin
            lon_arm_next = 1'b0;
            lon_next     = lon_reg & ~clr[`SFR_BIT_LEADS_ON];
        end else if (lon_sel_reg != lowpower_leadson_select) begin
            lon_arm_next = 1'b0;
            lon_next     = 1'b1;
        end else begin
            if (status_read) begin
                lon_arm_next = 1'b1;
            end
            lon_next = (lon_arm_reg & leads_on_cond) |
                       (lon_reg & ~clr[`SFR_BIT_LEADS_ON]);
        end

        // r event flag with its three clear sources
        case (r_event_clear_mode)
            `SFR_RCLR_RTOR: rev_next = rev_reg & ~rtor_read;
            `SFR_RCLR_SELF: rev_next = rev_reg & ~sample_instant;
            default:        rev_next = rev_reg & ~clr[`SFR_BIT_R_EVENT]; // reserved acts as 00
        endcase
        rev_next = rev_next | r_wave_pulse;

        // sample period tracking for the quarter-cycle self clear
        if (sample_instant) begin
            since_next    = 20'h00000;
            period_next   = since_reg;
            sample_sync_flag_div_next = sample_sync_flag_div_reg + 4'h1;
        end else begin
            since_next    = (since_reg == 20'hfffff) ? since_reg : since_reg + 20'h00001;
            period_next   = period_reg;
            sample_sync_flag_div_next = sample_sync_flag_div_reg;
        end
        if (sample_sync_clear_mode) begin
            sample_sync_flag_next = sample_sync_flag_reg & ~(since_reg >= {2'h0, period_reg[19:2]});
        end else begin
            sample_sync_flag_next = sample_sync_flag_reg & ~clr[`SFR_BIT_SAMPLE];
        end
        sample_sync_flag_next = sample_sync_flag_next | sample_sync_flag_issue;

        // pll unlock only counts while the pll can lock at all
        pll_next = (pll_unlocked & pll_powered & channel_enable) |
                   (pll_reg & ~clr[`SFR_BIT_PLL]);
    end

    // flag registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fast_reg      <= 1'b0;
            fast_prev_reg <= 1'b0;
            dcl_reg       <= 1'b0;
            detail_reg    <= 4'h0;
            loff_cnt_reg  <= 23'h000000;
            lon_reg       <= 1'b0;
            lon_arm_reg   <= 1'b0;
            lon_sel_reg   <= 2'h0;
            rev_reg       <= 1'b0;
            sample_sync_flag_reg      <= 1'b0;
            sample_sync_flag_div_reg  <= 4'h0;
            since_reg     <= 20'h00000;
            period_reg    <= 20'h00000;
            pll_reg       <= 1'b0;
        end else begin
            fast_reg      <= fast_next;
            fast_prev_reg <= fast_mode_active;
            dcl_reg       <= dcl_next;
            detail_reg    <= detail_next;
            loff_cnt_reg  <= loff_cnt_next;
            lon_reg       <= lon_next;
            lon_arm_reg   <= lon_arm_next;
            lon_sel_reg   <= lowpower_leadson_select;
            rev_reg       <= rev_next;
            sample_sync_flag_reg      <= sample_sync_flag_next;
            sample_sync_flag_div_reg  <= sample_sync_flag_div_next;
            since_reg     <= since_next;
            period_reg    <= period_next;
            pll_reg       <= pll_next;
        end
    end

    // ======================================================================
    // status word: raw flags, no enable masking, spare bits zero
    always_comb begin
        event_status                              = 24'h000000;
        event_status[`SFR_BIT_FAST]               = fast_reg;
        event_status[`SFR_BIT_DCLOFF]             = dcl_reg;
        event_status[`SFR_BIT_LEADS_ON]           = lon_reg;
        event_status[`SFR_BIT_R_EVENT]            = rev_reg;
        event_status[`SFR_BIT_SAMPLE]             = sample_sync_flag_reg;
        event_status[`SFR_BIT_PLL]                = pll_reg;
        event_status[`SFR_BIT_DETAIL_LO +: 4]     = detail_reg;
    end

endmodule // sfr_status_regs

// ===== hw/sfr_params.svh
// constants for the status flag register block: offsets, bit positions, timing
`ifndef SFR_PARAMS_SVH
`define SFR_PARAMS_SVH

// ==========================================================================
// register offsets (7-bit spi address)
`define SFR_REG_IDLE_LOW   7'h00
`define SFR_REG_STATUS     7'h01
`define SFR_REG_RTOR       7'h25
`define SFR_REG_IDLE_HIGH  7'h7f

// ==========================================================================
// event_status bit positions
`define SFR_BIT_FAST       21
`define SFR_BIT_DCLOFF     20
`define SFR_BIT_LEADS_ON   11
`define SFR_BIT_R_EVENT    10
`define SFR_BIT_SAMPLE     9
`define SFR_BIT_PLL        8
`define SFR_BIT_DETAIL_LO  0

// ==========================================================================
// reset values and codes
`define SFR_FLAGS_RESET    24'h000000
`define SFR_IDLE_READ      24'h000000
`define SFR_LON_SEL_A      2'h1
`define SFR_LON_SEL_B      2'h2
`define SFR_RCLR_STATUS    2'h0
`define SFR_RCLR_RTOR      2'h1
`define SFR_RCLR_SELF      2'h2

// ==========================================================================
// spi framing and timing
`define SFR_CMD_LAST_BIT   5'h07
`define SFR_FRAME_LAST_BIT 5'h1f
`define SFR_CLK_FREQ_HZ    20000000
`define SFR_LOFF_TIME_MS   115
`define SFR_LOFF_CYCLES    (`SFR_LOFF_TIME_MS * (`SFR_CLK_FREQ_HZ / 1000))

`endif

// ===== hw/sfr_pkg.sv
// types shared by the status flag register block
package sfr_pkg;
    // ======================================================================
    // spi frame states, one-hot
    typedef enum logic [3:0] {
        SFR_IDLE = 4'b0001,
        SFR_CMD  = 4'b0010,
        SFR_DATA = 4'b0100,
        SFR_DONE = 4'b1000
    } sfr_spi_state_t;
endpackage

// ===== verification/sfr_status_asserts.sv
// assertion checker for the status flag register ports
`timescale 1ns/10ps
module sfr_status_asserts #(
    parameter int LOFF_CYCLES = 20  // lead-off qualify time in clocks
) (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        csb_n,
    input wire logic        sdo,
    input wire logic        fast_mode_active,
    input wire logic        dc_leadoff_cond,
    input wire logic        r_wave_pulse,
    input wire logic        pll_unlocked,
    input wire logic        pll_powered,
    input wire logic        channel_enable,
    input wire logic [1:0]  lowpower_leadson_select,
    input wire logic [23:0] event_status
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // ==========================================================
    // run length of the lead-off condition, judges the qualify time
    int run_reg;   // clocks the condition has stood
    int run_next;  // next run length
    always_comb run_next = dc_leadoff_cond ? run_reg + 1 : 0;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) run_reg <= 0;
        else     run_reg <= run_next;
    end
    // ==========================================================
    // properties
    AST_SPARE: assert property ({event_status[23:22], event_status[19:12],
        event_status[7:4]} == 14'h0) else $error("spare status bit set");
    AST_SDO_QUIET: assert property (csb_n && $past(csb_n) |-> !sdo)
        else $error("sdo driven while deselected");
    AST_PLL_GATE: assert property ($rose(event_status[8]) |->
        $past(pll_unlocked && pll_powered && channel_enable)) else $error("pll flag ungated");
    AST_PLL_SET: assert property (pll_unlocked && pll_powered && channel_enable |=>
        event_status[8]) else $error("pll flag missing");
    AST_DCL_QUAL: assert property ($rose(event_status[20]) |-> run_reg > LOFF_CYCLES)
        else $error("lead-off flag too early");
    AST_DCL_HOLD: assert property (dc_leadoff_cond && event_status[20] |=>
        event_status[20]) else $error("lead-off flag dropped");
    AST_R_SET: assert property (r_wave_pulse |=> event_status[10])
        else $error("r flag missing");
    AST_FAST_SET: assert property ($rose(fast_mode_active) |=> event_status[21])
        else $error("fast flag missing");
    AST_LON_ENTRY: assert property ($changed(lowpower_leadson_select) &&
        lowpower_leadson_select inside {2'h1, 2'h2} |-> ##[1:2] event_status[11])
        else $error("leads-on flag missing");
endmodule // sfr_status_asserts

// ===== verification/sfr_host_model.sv
// host spi master model that frames register reads and writes
`timescale 1ns/10ps
module sfr_host_model (
    input  wire logic   clk,
    input  wire logic   sdo,
    output logic        csb_n,
    output logic        sclk,
    output logic        sdi,
    output logic        rd_done,
    output logic [23:0] rd_data
);
    logic sdi_drv;          // data bit of the running frame
    logic wander = 1'b0;    // level shown on the released data line
    // deselected, clock parked low in mode 0
    initial {csb_n, sclk, sdi_drv, rd_done, rd_data} = {4'b1000, 24'h0};
    // released data line wanders so a stale level never looks valid
    always @(negedge clk) wander <= ~wander;
    assign sdi = csb_n ? wander : sdi_drv;
    // ==========================================================
    // one whole 32-bit frame; levels held 2-3 clocks for edge detection
    task automatic xfer(input logic [6:0] addr, input logic rd, input logic [23:0] wdata);
        logic [31:0] frame;
        frame = {addr, rd, wdata};
        @(negedge clk) csb_n = 1'b0;
        @(negedge clk);
        for (int i = 31; i >= 0; i--) begin
            sdi_drv = frame[i];
            repeat (3) @(negedge clk);
            if (i < 24) rd_data[i] = sdo;  // settled since the last fall
            sclk = 1'b1;
            repeat (2) @(negedge clk);
            sclk = 1'b0;
        end
        repeat (3) @(negedge clk);
        csb_n = 1'b1;
        rd_done = rd;
        @(negedge clk) rd_done = 1'b0;
        @(negedge clk);
    endtask
endmodule // sfr_host_model

// ===== verification/status_flag_register_bench.sv
// self-checking bench for the status flag register block
`timescale 1ns/10ps
`include "sfr_params.svh"
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("[FAIL] %s exp %h got %h", n, e, g); end end
module status_flag_register_bench;
    localparam int LOFF = 20;  // short qualify time keeps the run brief
    logic        clk, rst, csb_n, sclk, sdi, sdo, rd_done, snap, cnt_sel, prev9;
    logic        fst, dcl, lon, rwp, smp, pll, pwr, chn, fmode, smode;
    logic [1:0]  lsel, rmode, sint;
    logic [3:0]  det;
    logic [7:0]  rises = 8'h0, base;  // observer-owned count, and its start mark
    logic [23:0] stat, rd_data, got, ee;
    int          error_cnt, n_checks, cyc, seed;
    string       en;
    string       nm_q[$];
    logic [23:0] exp_q[$];
    sfr_status_regs #(.LOFF_CYCLES(LOFF)) i_sfr_status_regs (
        .clk(clk), .rst(rst), .csb_n(csb_n), .sclk(sclk), .sdi(sdi), .sdo(sdo),
        .fast_mode_active(fst), .dc_leadoff_cond(dcl), .leadoff_detail(det),
        .leads_on_cond(lon), .r_wave_pulse(rwp), .sample_instant(smp),
        .pll_unlocked(pll), .pll_powered(pwr), .channel_enable(chn),
        .lowpower_leadson_select(lsel), .fast_flag_clear_mode(fmode),
        .r_event_clear_mode(rmode), .sample_sync_clear_mode(smode),
        .sample_sync_interval(sint), .event_status(stat));
    sfr_host_model i_sfr_host_model (.clk(clk), .sdo(sdo), .csb_n(csb_n), .sclk(sclk),
        .sdi(sdi), .rd_done(rd_done), .rd_data(rd_data));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // ==========================================================
    // observer: oldest note against the next read or snapshot
    always @(posedge clk) begin
        cyc++;
        prev9 <= stat[9];
        if (stat[9] && !prev9) rises <= rises + 8'h1;
        if (rd_done || snap) begin
            got = rd_done ? rd_data : (cnt_sel ? {16'h0, 8'(rises - base)} : stat);
            en = nm_q.pop_front();
            ee = exp_q.pop_front();
            `CHK(en, ee, got)
        end
        if (cyc == 20000) begin
            error_cnt++;
            finish_test();
        end
    end
    task automatic wt(input int n); repeat (n) @(negedge clk); endtask
    task automatic kick(ref logic s); s = 1'b1; wt(1); s = 1'b0; wt(1); endtask
    task automatic rd(input string n, input logic [6:0] a, input logic [23:0] e);
        nm_q.push_back(n);
        exp_q.push_back(e);
        i_sfr_host_model.xfer(a, 1'b1, 24'h0);
    endtask
    task automatic look(input string n, input logic [23:0] e);
        nm_q.push_back(n);
        exp_q.push_back(e);
        @(negedge clk) snap = 1'b1;
        @(negedge clk) snap = 1'b0;
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // ==========================================================
    // main sequence, inputs moved on the falling edge
    initial begin
        seed = 8380;
        {snap, cnt_sel, fst, dcl, lon, rwp, smp, pll, pwr, chn, fmode, smode} = 12'h0;
        {lsel, rmode, sint, det, base} = 18'h0;
        rst = 1'b1;
        repeat (2) @(posedge clk);
        @(negedge clk) rst = 1'b0;
        wt(2);
        look("reset", 24'h0);
        {pll, chn} = 2'b11;
        wt(2);
        look("pll_gated", 24'h0);
        {pwr, chn} = 2'b10;
        wt(2);
        look("pll_gated_ch", 24'h0);
        chn = 1'b1;
        wt(2);
        pll = 1'b0;
        for (int i = 0; i < 3; i++)
            i_sfr_host_model.xfer((i == 2) ? `SFR_REG_STATUS : 7'(i * 127), 1'b0,
                24'($random(seed)));
        rd("idle_low", `SFR_REG_IDLE_LOW, 24'h0);
        rd("idle_high", `SFR_REG_IDLE_HIGH, 24'h0);
        look("pll_held", 24'h000100);
        rd("pll_read", `SFR_REG_STATUS, 24'h000100);
        look("pll_clear", 24'h0);
        // lead-off must outlast the qualify time
        det = 4'($random(seed)) | 4'h1;
        dcl = 1'b1;
        wt(19);
        look("dcl_early", 24'h0);
        wt(11);
        look("dcl_set", 24'h100000 | 24'(det));
        dcl = 1'b0;
        wt(2);
        rd("dcl_read", `SFR_REG_STATUS, 24'h100000 | 24'(det));
        look("dcl_clear", 24'h0);
        // r flag under each clear code
        for (int m = 0; m < 4; m++) begin
            rmode = 2'(m);
            kick(rwp);
            look("r_set", 24'h000400);
            if (m == 2) kick(smp);
            if (m == 2) look("r_self", 24'h000200);
            rd("r_read", `SFR_REG_STATUS, (m == 2) ? 24'h000200 : 24'h000400);
            if (m == 1) look("r_kept", 24'h000400);
            if (m == 1) rd("rtor_read", `SFR_REG_RTOR, 24'h0);
            look("r_clear", 24'h0);
        end
        // sample flag divider, self-clearing so every issue is a fresh rise
        smode = 1'b1;
        for (int c = 0; c < 4; c++) begin
            sint = 2'(c);
            for (int k = 0; k < 19; k++) begin
                if (k == 3) base = rises;
                kick(smp);
                wt(18);
            end
            cnt_sel = 1'b1;
            look("sample_sync_flag_count", (c == 3) ? 24'h1 : 24'(16 >> c));
            cnt_sel = 1'b0;
        end
        look("sample_sync_flag_self", 24'h0);
        // fast flag, held then read-cleared
        fst = 1'b1;
        wt(2);
        rd("fast_read", `SFR_REG_STATUS, 24'h200000);
        look("fast_kept", 24'h200000);
        fst = 1'b0;
        wt(2);
        rd("fast_held", `SFR_REG_STATUS, 24'h200000);
        {fmode, fst} = 2'b11;
        wt(2);
        rd("fast_read1", `SFR_REG_STATUS, 24'h200000);
        look("fast_stay_clear", 24'h0);
        fst = 1'b0;
        // leads-on for both enabling codes
        for (int s = 1; s < 3; s++) begin
            lsel = 2'(s);
            wt(2);
            rd("lon_enable", `SFR_REG_STATUS, 24'h000800);
            look("lon_armed", 24'h0);
            lon = 1'b1;
            wt(2);
            lon = 1'b0;
            wt(2);
            rd("lon_held", `SFR_REG_STATUS, 24'h000800);
            look("lon_clear", 24'h0);
            lsel = 2'h0;
            wt(2);
        end
        finish_test();
    end
endmodule // status_flag_register_bench
bind sfr_status_regs sfr_status_asserts #(.LOFF_CYCLES(LOFF_CYCLES)) i_sfr_status_asserts (
    .clk(clk), .rst(rst), .csb_n(csb_n), .sdo(sdo), .fast_mode_active(fast_mode_active),
    .dc_leadoff_cond(dc_leadoff_cond), .r_wave_pulse(r_wave_pulse),
    .pll_unlocked(pll_unlocked), .pll_powered(pll_powered), .channel_enable(channel_enable),
    .lowpower_leadson_select(lowpower_leadson_select), .event_status(event_status));
